// ===== common/sclm_pkg.sv
/*
 * Shared constants and types for the speed reference loss supervisor.
 * Assumes a 40 MHz system clock; frequencies are unsigned 0.01 Hz steps.
 */
package sclm_pkg;

    localparam int          CLK_HZ            = 40_000_000;
    localparam int          FREQ_W            = 16;
    localparam int          TIME_W            = 11;
    // Decision time in tenths of a second
    localparam int          DEC_TIME_TENTHS   = 10;
    localparam int          DEC_TIME_MIN      = 1;
    localparam int          DEC_TIME_MAX      = 1200;
    localparam int          TENTH_S_CYC       = CLK_HZ / 10;
    // Averaging window for the hold modes
    localparam int          AVG_WINDOW_S      = 10;
    localparam int          AVG_SLOTS         = 16;
    localparam int          AVG_SLOT_CYC      =
        (CLK_HZ / AVG_SLOTS) * AVG_WINDOW_S;
    localparam int          AVG_SHIFT         = 4;
    // Stop ramp period per 0.01 Hz step, default arbitrary
    localparam int          DEC_STEP_CYC      = 400;

    localparam logic [2:0]  MODE_NONE         = 3'h0;
    localparam logic [2:0]  MODE_FREE_RUN     = 3'h1;
    localparam logic [2:0]  MODE_DEC          = 3'h2;
    localparam logic [2:0]  MODE_HOLD_IN      = 3'h3;
    localparam logic [2:0]  MODE_HOLD_OUT     = 3'h4;
    localparam logic [2:0]  MODE_PRESET       = 3'h5;
    localparam logic [2:0]  MODE_RESET        = MODE_FREE_RUN;

    localparam logic [1:0]  SRC_ANALOG        = 2'h0;
    localparam logic [1:0]  SRC_LINK          = 2'h1;
    localparam logic [1:0]  SRC_KEYPAD        = 2'h2;

    localparam logic [FREQ_W-1:0] PRESET_RESET = 16'h0000;

    localparam logic [7:0]  ADR_MODE          = 8'h00;
    localparam logic [7:0]  ADR_TIME          = 8'h04;
    localparam logic [7:0]  ADR_PRESET        = 8'h08;
    localparam logic [7:0]  ADR_LEVEL         = 8'h0c;
    localparam logic [7:0]  ADR_START_F       = 8'h10;
    localparam logic [7:0]  ADR_MAX_F         = 8'h14;
    localparam logic [7:0]  ADR_X1            = 8'h18;
    localparam logic [7:0]  ADR_STATUS        = 8'h1c;
    localparam logic [7:0]  ADR_FREQ          = 8'h20;
    localparam logic [FREQ_W-1:0] MAX_F_RESET = 16'h1770;

    typedef enum logic [1:0] {
        SCLM_NORMAL,
        SCLM_QUALIFY,
        SCLM_LOST
    } sclm_state_type;

endpackage

// ===== hdl/sclm_timer.sv
/*
 * Loss qualification timer: counts tenths of a second while armed.
 * Assumes arm_i and limit_i come from the system clock domain.
 */
module sclm_timer
    import sclm_pkg::*;
#(
    parameter int TENTH_CYC = TENTH_S_CYC
)
(
    input  wire logic              clk_sys_i,
    input  wire logic              rst_b_i,
    input  wire logic              ce_i,
    input  wire logic              arm_i,
    input  wire logic [TIME_W-1:0] limit_i,
    output logic                   expired_o
);
    typedef struct packed {
        logic [31:0]       pre;
        logic [TIME_W-1:0] tenths;
        logic              done;
    } sclm_tmr_type;

    sclm_tmr_type r;
    sclm_tmr_type next_r;

    always_comb
    begin
        next_r = r;
        if (!arm_i)
        begin
            // Clearing while disarmed restarts qualification
            next_r = '0;
        end
        else if (!r.done)
        begin
            if (r.pre == 32'(TENTH_CYC - 1))
            begin
                next_r.pre    = '0;
                next_r.tenths = r.tenths + 1'b1;
                if (r.tenths + 1'b1 >= limit_i)
                begin
                    next_r.done = 1'b1;
                end
            end
            else
            begin
                next_r.pre = r.pre + 32'd1;
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            r <= '0;
        end
        else if (ce_i)
        begin
            r <= next_r;
        end
    end

    assign expired_o = r.done;
endmodule

// ===== hdl/sclm_avg.sv
/*
 * Moving average over a ten second window in equal slots.
 * Slot values live in registers; the window sum is kept incrementally.
 * Assumes sample_i is a system clock domain value.
 */
module sclm_avg
    import sclm_pkg::*;
#(
    parameter int SLOT_CYC = AVG_SLOT_CYC
)
(
    input  wire logic              clk_sys_i,
    input  wire logic              rst_b_i,
    input  wire logic              ce_i,
    input  wire logic              run_i,
    input  wire logic [FREQ_W-1:0] sample_i,
    output logic [FREQ_W-1:0]      avg_o
);
    // Slot value is the last sample of the slot, which keeps the
    // adder narrow; a true integral would need 41-bit slot sums.
    typedef struct packed {
        logic [31:0]                   cnt;
        logic [AVG_SLOTS*FREQ_W-1:0]   slots;
        logic [FREQ_W+AVG_SHIFT-1:0]   sum;
        logic [FREQ_W-1:0]             avg;
    } sclm_avg_type;

    sclm_avg_type r;
    sclm_avg_type next_r;

    always_comb
    begin
        next_r = r;
        if (run_i)
        begin
            if (r.cnt == 32'(SLOT_CYC - 1))
            begin
                next_r.cnt   = '0;
                next_r.slots = {r.slots[(AVG_SLOTS-1)*FREQ_W-1:0],
                                sample_i};
                next_r.sum   = r.sum + (FREQ_W+AVG_SHIFT)'(sample_i)
                    - (FREQ_W+AVG_SHIFT)'(
                      r.slots[AVG_SLOTS*FREQ_W-1 -: FREQ_W]);
            end
            else
            begin
                next_r.cnt = r.cnt + 32'd1;
            end
        end
        next_r.avg = r.sum[FREQ_W+AVG_SHIFT-1:AVG_SHIFT];
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            r <= '0;
        end
        else if (ce_i)
        begin
            r <= next_r;
        end
    end

    assign avg_o = r.avg;
endmodule

// ===== hdl/sclm_top.sv
/*
 * Speed reference loss supervisor: qualifies loss of the analog or link
 * reference (the keypad is never lost) and applies the selected reaction to the
 * operating frequency. Registers via a plain strobe port.
 * Assumes analog samples and link_alive_i arrive asynchronously from
 * the converter and link logic; the rest is on clk_sys_i.
 */
// Decided for this implementation: the placing of the registers and the strobed register port.
module sclm_top
    import sclm_pkg::*;
#(
    parameter int TENTH_CYC = TENTH_S_CYC,
    parameter int SLOT_CYC  = AVG_SLOT_CYC,
    parameter int STEP_CYC  = DEC_STEP_CYC
)
(
    input  wire logic                  clk_sys_i,
    input  wire logic                  rst_b_i,
    input  wire logic                  ce_i,
    input  wire logic [1:0]            source_i,
    input  wire logic [FREQ_W-1:0]     analog_i,
    input  wire logic                  link_alive_i,
    input  wire logic [FREQ_W-1:0]     reference_i,
    input  wire logic [7:0]            addr_i,
    input  wire logic [FREQ_W-1:0]     wdata_i,
    input  wire logic                  wr_i,
    input  wire logic                  rd_i,
    output logic [FREQ_W-1:0]          rdata_o,
    output logic [FREQ_W-1:0]          freq_o,
    output logic                       out_block_o,
    output logic                       digital_output_one_o
);
    import sclm_pkg::*;

    typedef struct packed {
        logic [FREQ_W-1:0] an_s1;
        logic [FREQ_W-1:0] an_s2;
        logic              lk_s1;
        logic              lk_s2;
        logic [2:0]        mode;
        logic [TIME_W-1:0] dtime;
        logic [FREQ_W-1:0] preset;
        logic              analog_loss_threshold_select;
        logic [FREQ_W-1:0] start_f;
        logic [FREQ_W-1:0] max_f;
        logic [FREQ_W-1:0] x1;
        sclm_state_type    st;
        logic [FREQ_W-1:0] held;
        logic [FREQ_W-1:0] freq;
        logic              block;
        logic              lost_out;
        logic [31:0]       step;
        logic [FREQ_W-1:0] rdata;
    } sclm_top_type;

    sclm_top_type r;
    sclm_top_type next_r;

    logic              low_ref;
    logic              expired;
    logic [FREQ_W-1:0] avg_in;
    logic [FREQ_W-1:0] avg_out;
    logic [FREQ_W-1:0] threshold_half_ref;
    logic [FREQ_W-1:0] threshold_full_ref;
    logic [FREQ_W-1:0] ref_now;
    logic [FREQ_W-1:0] wclamp;

    assign threshold_half_ref = {1'b0, r.x1[FREQ_W-1:1]};
    assign threshold_full_ref = r.x1;
    assign ref_now = (source_i == SRC_ANALOG) ? r.an_s2 : reference_i;

    // Keypad never loses its value; only analog and link qualify
    always_comb
    begin
        low_ref = 1'b0;
        case (source_i)
            SRC_ANALOG:
            begin
                if (r.analog_loss_threshold_select)
                begin
                    low_ref = r.an_s2 < threshold_full_ref;
                end
                else
                begin
                    low_ref = r.an_s2 < threshold_half_ref;
                end
            end
            SRC_LINK:   low_ref = !r.lk_s2;
            SRC_KEYPAD: low_ref = 1'b0;
            default:    low_ref = 1'b0;
        endcase
    end

    sclm_timer #(
        .TENTH_CYC (TENTH_CYC)
    ) u_timer (
        .clk_sys_i (clk_sys_i),
        .rst_b_i   (rst_b_i),
        .ce_i      (ce_i),
        .arm_i     (low_ref && r.mode != MODE_NONE),
        .limit_i   (r.dtime),
        .expired_o (expired)
    );

    // Averagers freeze once qualification starts so the held value stays
    sclm_avg #(
        .SLOT_CYC  (SLOT_CYC)
    ) u_avg_in (
        .clk_sys_i (clk_sys_i),
        .rst_b_i   (rst_b_i),
        .ce_i      (ce_i),
        .run_i     (r.st == SCLM_NORMAL),
        .sample_i  (ref_now),
        .avg_o     (avg_in)
    );

    sclm_avg #(
        .SLOT_CYC  (SLOT_CYC)
    ) u_avg_out (
        .clk_sys_i (clk_sys_i),
        .rst_b_i   (rst_b_i),
        .ce_i      (ce_i),
        .run_i     (r.st == SCLM_NORMAL),
        .sample_i  (r.freq),
        .avg_o     (avg_out)
    );

    always_comb
    begin
        wclamp = wdata_i;
        if (wdata_i < r.start_f)
        begin
            wclamp = r.start_f;
        end
        else if (wdata_i > r.max_f)
        begin
            wclamp = r.max_f;
        end
    end

    always_comb
    begin
        next_r = r;
        next_r.an_s1 = analog_i;
        next_r.an_s2 = r.an_s1;
        next_r.lk_s1 = link_alive_i;
        next_r.lk_s2 = r.lk_s1;

        if (wr_i)
        begin
            case (addr_i)
                ADR_MODE:    next_r.mode = wdata_i[2:0];
                ADR_TIME:
                begin
                    if (wdata_i < FREQ_W'(DEC_TIME_MIN))
                    begin
                        next_r.dtime = TIME_W'(DEC_TIME_MIN);
                    end
                    else if (wdata_i > FREQ_W'(DEC_TIME_MAX))
                    begin
                        next_r.dtime = TIME_W'(DEC_TIME_MAX);
                    end
                    else
                    begin
                        next_r.dtime = wdata_i[TIME_W-1:0];
                    end
                end
                ADR_PRESET:  next_r.preset = wclamp;
                ADR_LEVEL:
                begin
                    next_r.analog_loss_threshold_select = wdata_i[0];
                end
                ADR_START_F: next_r.start_f = wdata_i;
                ADR_MAX_F:   next_r.max_f = wdata_i;
                ADR_X1:      next_r.x1 = wdata_i;
                default:     next_r.mode = r.mode;
            endcase
        end

        next_r.rdata = '0;
        if (rd_i)
        begin
            case (addr_i)
                ADR_MODE:    next_r.rdata = FREQ_W'(r.mode);
                ADR_TIME:    next_r.rdata = FREQ_W'(r.dtime);
                ADR_PRESET:  next_r.rdata = r.preset;
                ADR_LEVEL:
                begin
                    next_r.rdata = FREQ_W'(r.analog_loss_threshold_select);
                end
                ADR_START_F: next_r.rdata = r.start_f;
                ADR_MAX_F:   next_r.rdata = r.max_f;
                ADR_X1:      next_r.rdata = r.x1;
                ADR_STATUS:
                begin
                    next_r.rdata = {13'h0000, r.block, r.lost_out,
                                    low_ref};
                end
                ADR_FREQ:    next_r.rdata = r.freq;
                default:     next_r.rdata = '0;
            endcase
        end

        // Loss detection on the analog and link sources; keypad never qualifies
        case (r.st)
            SCLM_NORMAL:
            begin
                if (low_ref && r.mode != MODE_NONE)
                begin
                    next_r.st = SCLM_QUALIFY;
                end
            end
            SCLM_QUALIFY:
            begin
                if (!low_ref)
                begin
                    next_r.st = SCLM_NORMAL;
                end
                else if (expired)
                begin
                    next_r.st = SCLM_LOST;
                    next_r.held = (r.mode == MODE_HOLD_IN) ? avg_in
                                                           : avg_out;
                end
            end
            SCLM_LOST:
            begin
                if (!low_ref || r.mode == MODE_NONE)
                begin
                    next_r.st = SCLM_NORMAL;
                end
            end
            default: next_r.st = SCLM_NORMAL;
        endcase

        next_r.lost_out = (next_r.st == SCLM_LOST);
        next_r.block = 1'b0;
        next_r.step  = '0;
        if (next_r.st != SCLM_LOST || r.mode == MODE_NONE)
        begin
            next_r.freq = ref_now;
        end
        else
        begin
            case (r.mode)
                MODE_FREE_RUN:
                begin
                    next_r.block = 1'b1;
                    next_r.freq  = '0;
                end
                MODE_DEC:
                begin
                    // Linear ramp, one step per period
                    next_r.step = r.step + 32'd1;
                    if (r.step >= 32'(STEP_CYC - 1))
                    begin
                        next_r.step = '0;
                        if (r.freq != '0)
                        begin
                            next_r.freq = r.freq - 1'b1;
                        end
                    end
                    if (r.freq == '0)
                    begin
                        next_r.block = 1'b1;
                    end
                end
                // Use the value just captured, not the stale one
                MODE_HOLD_IN:  next_r.freq = next_r.held;
                MODE_HOLD_OUT: next_r.freq = next_r.held;
                MODE_PRESET:   next_r.freq = r.preset;
                default:       next_r.freq = ref_now;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            r         <= '0;
            r.mode    <= MODE_RESET;
            r.dtime   <= TIME_W'(DEC_TIME_TENTHS);
            r.preset  <= PRESET_RESET;
            r.max_f   <= MAX_F_RESET;
            r.st      <= SCLM_NORMAL;
        end
        else if (ce_i)
        begin
            r <= next_r;
        end
    end

    assign rdata_o              = r.rdata;
    assign freq_o               = r.freq;
    assign out_block_o          = r.block;
    assign digital_output_one_o = r.lost_out;

    AST_LOST_OUT: assert property (@(posedge clk_sys_i) disable iff
        (!rst_b_i) (ce_i && !low_ref) |=> !digital_output_one_o)
        else $error("loss output mismatch");

    AST_LOST_SET: assert property (@(posedge clk_sys_i) disable iff
        (!rst_b_i) (ce_i && r.st == SCLM_QUALIFY && low_ref && expired)
        |=> digital_output_one_o)
        else $error("loss output not raised");

    AST_FREE_RUN: assert property (@(posedge clk_sys_i) disable iff
        (!rst_b_i) (ce_i && r.st == SCLM_LOST && r.mode == MODE_FREE_RUN
        && low_ref) |=> out_block_o)
        else $error("free run did not block");

    AST_PASS: assert property (@(posedge clk_sys_i) disable iff
        (!rst_b_i) (ce_i && r.mode == MODE_NONE) |=> !digital_output_one_o
        && freq_o == $past(ref_now))
        else $error("mode none not passing");

    AST_PRESET: assert property (@(posedge clk_sys_i) disable iff
        (!rst_b_i) (ce_i && r.st == SCLM_LOST && r.mode == MODE_PRESET
        && next_r.st == SCLM_LOST) |=> freq_o == $past(r.preset))
        else $error("preset not applied");

    AST_RECOVER: assert property (@(posedge clk_sys_i) disable iff
        (!rst_b_i) (ce_i && r.st == SCLM_QUALIFY && !low_ref)
        |=> r.st == SCLM_NORMAL)
        else $error("qualification not cleared");

    AST_PRESET_RANGE: assert property (@(posedge clk_sys_i) disable iff
        (!rst_b_i) (ce_i && wr_i && addr_i == ADR_PRESET)
        |=> r.preset >= $past(r.start_f))
        else $error("preset below start");

    AST_NO_EARLY: assert property (@(posedge clk_sys_i) disable iff
        (!rst_b_i) (ce_i && r.st == SCLM_NORMAL) |=> r.st != SCLM_LOST)
        else $error("loss without qualification");

    AST_HOLD: assert property (@(posedge clk_sys_i) disable iff
        (!rst_b_i) (ce_i && r.st == SCLM_LOST && next_r.st == SCLM_LOST
        && r.mode == MODE_HOLD_IN) |=> freq_o == $past(r.held))
        else $error("held input not used");
endmodule

// ===== dv/sclm_ref_model.sv
/*
 * Far side model: the analog terminal, the serial link and the keypad
 * that feed the speed reference into the loss supervisor.
 * Assumes the bench opens and closes the cable with cut_i.
 */
module sclm_ref_model
    import sclm_pkg::*;
(
    input  wire logic              clk_sys_i,
    input  wire logic              cut_i,
    input  wire logic [1:0]        sel_i,
    input  wire logic [FREQ_W-1:0] ana_val_i,
    input  wire logic [FREQ_W-1:0] ref_val_i,
    output logic [1:0]             source_o,
    output logic [FREQ_W-1:0]      analog_o,
    output logic                   link_alive_o,
    output logic [FREQ_W-1:0]      reference_o
);
    timeunit 1ns;
    timeprecision 100ps;

    int unsigned cut_cyc;

    initial
    begin
        cut_cyc      = 0;
        source_o     = SRC_KEYPAD;
        analog_o     = '0;
        link_alive_o = 1'b1;
        reference_o  = '0;
    end

    always @(posedge clk_sys_i)
    begin
        source_o     <= sel_i;
        // Broken analog cable falls to the input's pull-down
        analog_o     <= cut_i ? '0 : ana_val_i;
        link_alive_o <= !cut_i;
        cut_cyc      <= cut_i ? cut_cyc + 1 : 0;
        // Dead link: last word held briefly, then garbage
        if (!cut_i || cut_cyc < 8)
            reference_o <= ref_val_i;
        else
            reference_o <= ~reference_o;
    end
endmodule

// ===== dv/testbench.sv
/*
 * Self-checking bench for the loss supervisor: register tasks on the
 * strobe port, reference source model on the far side.
 * Assumes the shortened timer, slot and ramp counts set below.
 */
module testbench
    import sclm_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic              clk_sys_i = 1'b0;
    logic              rst_b_i   = 1'b0;
    logic              ce_i      = 1'b1;
    logic              wr_i      = 1'b0;
    logic              rd_i      = 1'b0;
    logic              cut       = 1'b0;
    logic [1:0]        sel       = SRC_KEYPAD;
    logic [7:0]        addr_i    = 8'h00;
    logic [FREQ_W-1:0] wdata_i   = 16'h0000;
    logic [FREQ_W-1:0] ana_val   = 16'h07d0;
    logic [FREQ_W-1:0] ref_val   = 16'h0000;
    logic [1:0]        source_i;
    logic [FREQ_W-1:0] analog_i;
    logic              link_alive_i;
    logic [FREQ_W-1:0] reference_i;
    logic [FREQ_W-1:0] rdata_o;
    logic [FREQ_W-1:0] freq_o;
    logic              out_block_o;
    logic              digital_output_one_o;
    logic [FREQ_W-1:0] f1;
    int                err_count = 0;
    int                checked   = 0;
    int                c;

    always #12.5 clk_sys_i = ~clk_sys_i;

    sclm_ref_model i_src (
        .clk_sys_i    (clk_sys_i),
        .cut_i        (cut),
        .sel_i        (sel),
        .ana_val_i    (ana_val),
        .ref_val_i    (ref_val),
        .source_o     (source_i),
        .analog_o     (analog_i),
        .link_alive_o (link_alive_i),
        .reference_o  (reference_i)
    );

    sclm_top #(.TENTH_CYC(10), .SLOT_CYC(4), .STEP_CYC(2)) i_dut (
        .clk_sys_i            (clk_sys_i),
        .rst_b_i              (rst_b_i),
        .ce_i                 (ce_i),
        .source_i             (source_i),
        .analog_i             (analog_i),
        .link_alive_i         (link_alive_i),
        .reference_i          (reference_i),
        .addr_i               (addr_i),
        .wdata_i              (wdata_i),
        .wr_i                 (wr_i),
        .rd_i                 (rd_i),
        .rdata_o              (rdata_o),
        .freq_o               (freq_o),
        .out_block_o          (out_block_o),
        .digital_output_one_o (digital_output_one_o)
    );

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_sys_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_sys_i);
        wr_i    <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clk_sys_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_sys_i);
        rd_i   <= 1'b0;
        #1;
        check(rdata_o, exp);
    endtask

    task automatic wait_loss(input logic lvl, input int n);
        c = 0;
        while (digital_output_one_o !== lvl && c < n)
        begin
            @(posedge clk_sys_i);
            #1;
            c++;
        end
        check(16'(digital_output_one_o), 16'(lvl));
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask

    task automatic final_report();
        $display("errors %0d checks %0d", err_count, checked);
        if (err_count == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge clk_sys_i);
        err_count++;
        final_report();
    end

    initial
    begin
        repeat (12) @(posedge clk_sys_i);
        rst_b_i <= 1'b1;
        rd_chk(ADR_MODE, 16'h0001);
        rd_chk(ADR_TIME, 16'h000a);
        rd_chk(ADR_PRESET, 16'h0000);
        rd_chk(ADR_MAX_F, 16'h1770);
        rd_chk(8'h30, 16'h0000);
        @(posedge clk_sys_i);
        ce_i <= 1'b0;
        wr_reg(ADR_PRESET, 16'h0010);
        ce_i <= 1'b1;
        rd_chk(ADR_PRESET, 16'h0000);
        // Preset is clamped into start..max when written
        wr_reg(ADR_START_F, 16'h0064);
        wr_reg(ADR_PRESET, 16'h0032);
        rd_chk(ADR_PRESET, 16'h0064);
        wr_reg(ADR_PRESET, 16'hffff);
        rd_chk(ADR_PRESET, 16'h1770);
        wr_reg(ADR_PRESET, 16'h0200);
        rd_chk(ADR_PRESET, 16'h0200);
        wr_reg(ADR_MODE, 16'h0000);
        ref_val <= 16'h1234;
        idle(6);
        check(freq_o, 16'h1234);
        wr_reg(ADR_X1, 16'h03e8);
        wr_reg(ADR_TIME, 16'h0003);
        sel     <= SRC_ANALOG;
        ana_val <= 16'h0000;
        idle(80);
        check(16'(digital_output_one_o), 16'h0000);
        check(16'(out_block_o), 16'h0000);
        ana_val <= 16'h07d0;
        wr_reg(ADR_MODE, 16'h0001);
        ana_val <= 16'h0258;
        idle(80);
        check(16'(digital_output_one_o), 16'h0000);
        ana_val <= 16'h0190;
        wait_loss(1'b1, 80);
        check(16'(c >= 25), 16'h0001);
        check(16'(digital_output_one_o), 16'h0001);
        check(16'(out_block_o), 16'h0001);
        rd_chk(ADR_STATUS, 16'h0007);
        ana_val <= 16'h07d0;
        wait_loss(1'b0, 20);
        check(16'(digital_output_one_o), 16'h0000);
        check(16'(out_block_o), 16'h0000);
        // Short dips add up past the decision time only if not cleared
        repeat (4)
        begin
            ana_val <= 16'h0190;
            idle(20);
            ana_val <= 16'h07d0;
            idle(6);
            check(16'(digital_output_one_o), 16'h0000);
        end
        wr_reg(ADR_LEVEL, 16'h0001);
        wr_reg(ADR_MODE, 16'h0005);
        ana_val <= 16'h0384;
        wait_loss(1'b1, 80);
        check(16'(digital_output_one_o), 16'h0001);
        idle(2);
        check(freq_o, 16'h0200);
        ana_val <= 16'h07d0;
        wait_loss(1'b0, 20);
        wr_reg(ADR_MODE, 16'h0002);
        sel     <= SRC_LINK;
        ref_val <= 16'h0014;
        idle(10);
        cut <= 1'b1;
        wait_loss(1'b1, 100);
        check(16'(c >= 25 && c <= 50), 16'h0001);
        f1 = freq_o;
        idle(10);
        f1 = f1 - freq_o;
        check(16'(f1 >= 16'd4 && f1 <= 16'd6), 16'h0001);
        idle(60);
        check(freq_o, 16'h0000);
        check(16'(out_block_o), 16'h0001);
        cut <= 1'b0;
        wait_loss(1'b0, 20);
        ref_val <= 16'h0800;
        wr_reg(ADR_MODE, 16'h0003);
        idle(100);
        cut <= 1'b1;
        wait_loss(1'b1, 100);
        check(freq_o, 16'h0800);
        cut <= 1'b0;
        wait_loss(1'b0, 20);
        wr_reg(ADR_MODE, 16'h0004);
        idle(100);
        cut <= 1'b1;
        wait_loss(1'b1, 100);
        check(freq_o, 16'h0800);
        cut <= 1'b0;
        idle(10);
        final_report();
    end
endmodule
